// >>> include/tepc_pkg.sv
`default_nettype none
package tepc_pkg;

    // Printed offsets are register indices; byte address is four times that
    localparam logic [7:0] IDX_CONTROL = 8'h15;
    localparam logic [7:0] IDX_COMPARE = 8'h19;
    localparam logic [7:0] IDX_STATUS = 8'h1A;
    localparam logic [9:0] ADDR_CONTROL = {IDX_CONTROL, 2'b00};
    localparam logic [9:0] ADDR_COMPARE = {IDX_COMPARE, 2'b00};
    localparam logic [9:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
    localparam int ADDR_W = 10;

    // timer_control fields
    localparam int RUN_BIT_POS = 5;
    localparam int CSEL_LSB = 2;
    localparam int CSEL_W = 3;
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 2;

    // status fields
    localparam int STAT_CNT_LSB = 0;
    localparam int STAT_DIV_POS = 8;
    localparam int STAT_PWM_POS = 9;
    localparam int STAT_ACT_LSB = 16;

    // Reset values, counter top, external select code and internal source count
    localparam logic [7:0] COMPARE_RESET = 8'hFF;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] COUNT_TOP = 8'hFF;
    localparam logic [2:0] CSEL_RESET = 3'h0;
    localparam logic [2:0] CSEL_EXTERNAL = 3'h7;
    localparam int N_INT_SRC = 7;

    // Event input pulse width floor, in high-frequency clock periods
    localparam int EVENT_MIN_FC_PERIODS = 8;

    typedef enum logic [1:0] {
        MODE_TIMER = 2'b00,
        MODE_RSVD = 2'b01,
        MODE_PDO = 2'b10,
        MODE_PWM = 2'b11
    } tepc_mode_t;

    localparam logic [1:0] MODE_RESET = 2'b00;

endpackage : tepc_pkg
`default_nettype wire

// >>> logic/tepc_timer.sv
`timescale 1ns/1ps
`default_nettype none
module tepc_timer (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tepc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [tepc_pkg::N_INT_SRC-1:0] src_tick,
    input wire logic event_in,
    input wire logic low_speed_mode,
    input wire logic stop_mode_entry,
    output logic match_irq,
    output logic divider_out,
    output logic pwm_out_n
);

    typedef struct packed {
        logic [7:0] cnt;
        logic [7:0] cmp;
        logic [7:0] act;
        logic run;
        logic [2:0] csel;
        logic [1:0] mode;
        logic div;
        logic pwm_n;
        logic irq;
        logic ev_s1;
        logic ev_s2;
        logic ev_s3;
        logic rdy;
        logic err;
        logic [31:0] rdata;
    } tepc_state_t;

    tepc_state_t st_reg;
    tepc_state_t st_next;
    logic ev_rise;
    logic ev_fall;
    logic int_tick;
    logic ext_sel;
    logic wr_ctrl;
    logic wr_cmp;
    logic addr_ok;

    // Only the second and third stages feed the edge detector
    assign ev_rise = st_reg.ev_s2 & ~st_reg.ev_s3;
    assign ev_fall = ~st_reg.ev_s2 & st_reg.ev_s3;
    assign ext_sel = (st_reg.csel == tepc_pkg::CSEL_EXTERNAL);
    assign int_tick = ext_sel ? 1'b0 : src_tick[st_reg.csel];
    assign addr_ok = (paddr == tepc_pkg::ADDR_CONTROL)
        || (paddr == tepc_pkg::ADDR_COMPARE)
        || (paddr == tepc_pkg::ADDR_STATUS);
    // Writes land only at the completing access edge
    assign wr_ctrl = psel && penable && pwrite && st_reg.rdy
        && (paddr == tepc_pkg::ADDR_CONTROL);
    assign wr_cmp = psel && penable && pwrite && st_reg.rdy
        && (paddr == tepc_pkg::ADDR_COMPARE);

    always_comb begin
        st_next = st_reg;
        st_next.irq = 1'b0;
        st_next.ev_s1 = event_in;
        st_next.ev_s2 = st_reg.ev_s1;
        st_next.ev_s3 = st_reg.ev_s2;
        if (st_reg.run) begin
            case (st_reg.mode)
                tepc_pkg::MODE_TIMER: begin
                    if (ext_sel) begin
                        // Low-speed modes have no event clock
                        if (!low_speed_mode) begin
                            if (ev_rise) begin
                                st_next.cnt = st_reg.cnt + 8'h01;
                            end else if (ev_fall
                                && st_reg.cnt == st_reg.cmp) begin
                                st_next.irq = 1'b1;
                                st_next.cnt = tepc_pkg::COUNT_RESET;
                            end
                        end
                    end else if (int_tick) begin
                        if (st_reg.cnt == st_reg.cmp) begin
                            st_next.irq = 1'b1;
                            st_next.cnt = tepc_pkg::COUNT_RESET;
                        end else begin
                            st_next.cnt = st_reg.cnt + 8'h01;
                        end
                    end
                end
                tepc_pkg::MODE_PDO: begin
                    if (int_tick) begin
                        if (st_reg.cnt == st_reg.cmp) begin
                            st_next.div = ~st_reg.div;
                            st_next.irq = 1'b1;
                            st_next.cnt = tepc_pkg::COUNT_RESET;
                        end else begin
                            st_next.cnt = st_reg.cnt + 8'h01;
                        end
                    end
                end
                tepc_pkg::MODE_PWM: begin
                    if (int_tick && !low_speed_mode) begin
                        st_next.cnt = st_reg.cnt + 8'h01;
                        if (st_reg.cnt == tepc_pkg::COUNT_TOP) begin
                            st_next.pwm_n = 1'b1;
                            st_next.irq = 1'b1;
                            // Shadow moves at cycle end and on a software start
                            st_next.act = st_reg.cmp;
                        end else if (st_reg.cnt + 8'h01 == st_reg.act) begin
                            st_next.pwm_n = 1'b0;
                        end
                    end
                end
                default: begin
                    // Reserved mode holds the counter
                    st_next.cnt = st_reg.cnt;
                end
            endcase
        end else begin
            st_next.cnt = tepc_pkg::COUNT_RESET;
            st_next.div = 1'b1;
            st_next.pwm_n = 1'b1;
        end
        // APB: answer with no wait state, data taken in setup
        st_next.rdy = psel && !penable;
        st_next.err = psel && !penable && !addr_ok;
        st_next.rdata = 32'h0000_0000;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                tepc_pkg::ADDR_CONTROL: begin
                    st_next.rdata[tepc_pkg::RUN_BIT_POS] = st_reg.run;
                    st_next.rdata[tepc_pkg::CSEL_LSB +: tepc_pkg::CSEL_W]
                        = st_reg.csel;
                    st_next.rdata[tepc_pkg::MODE_LSB +: tepc_pkg::MODE_W]
                        = st_reg.mode;
                end
                tepc_pkg::ADDR_COMPARE: begin
                    st_next.rdata[7:0] = st_reg.cmp;
                end
                tepc_pkg::ADDR_STATUS: begin
                    st_next.rdata[tepc_pkg::STAT_CNT_LSB +: 8] = st_reg.cnt;
                    st_next.rdata[tepc_pkg::STAT_DIV_POS] = st_reg.div;
                    st_next.rdata[tepc_pkg::STAT_PWM_POS] = st_reg.pwm_n;
                    st_next.rdata[tepc_pkg::STAT_ACT_LSB +: 8] = st_reg.act;
                end
                default: begin
                    st_next.rdata = 32'h0000_0000;
                end
            endcase
        end
        if (wr_cmp) begin
            // In PWM mode this is the shadow stage only
            st_next.cmp = pwdata[7:0];
        end
        if (wr_ctrl) begin
            st_next.run = pwdata[tepc_pkg::RUN_BIT_POS];
            st_next.csel = pwdata[tepc_pkg::CSEL_LSB +: tepc_pkg::CSEL_W];
            st_next.mode = pwdata[tepc_pkg::MODE_LSB +: tepc_pkg::MODE_W];
            if (pwdata[tepc_pkg::RUN_BIT_POS] && !st_reg.run) begin
                st_next.cnt = tepc_pkg::COUNT_RESET;
                st_next.div = 1'b1;
                st_next.pwm_n = 1'b1;
                st_next.act = st_reg.cmp;
            end
        end
        // Stop power mode outranks a software start in the same cycle
        if (stop_mode_entry) begin
            st_next.run = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
            st_reg.cnt <= tepc_pkg::COUNT_RESET;
            st_reg.cmp <= tepc_pkg::COMPARE_RESET;
            st_reg.act <= tepc_pkg::COMPARE_RESET;
            st_reg.csel <= tepc_pkg::CSEL_RESET;
            st_reg.mode <= tepc_pkg::MODE_RESET;
            st_reg.div <= 1'b1;
            st_reg.pwm_n <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata = st_reg.rdata;
    assign pready = st_reg.rdy;
    assign pslverr = st_reg.err;
    assign match_irq = st_reg.irq;
    assign divider_out = st_reg.div;
    assign pwm_out_n = st_reg.pwm_n;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    logic timer_on;
    logic event_on;
    logic pdo_on;
    logic pwm_on;
    assign timer_on = st_reg.run && st_reg.mode == tepc_pkg::MODE_TIMER
        && !ext_sel && !wr_ctrl && !stop_mode_entry;
    assign event_on = st_reg.run && st_reg.mode == tepc_pkg::MODE_TIMER
        && ext_sel && !wr_ctrl && !stop_mode_entry;
    assign pdo_on = st_reg.run && st_reg.mode == tepc_pkg::MODE_PDO
        && !wr_ctrl && !stop_mode_entry;
    assign pwm_on = st_reg.run && st_reg.mode == tepc_pkg::MODE_PWM
        && !wr_ctrl && !stop_mode_entry && !low_speed_mode;

    sequence s_event_rise_seen;
        event_on && !low_speed_mode && ev_rise;
    endsequence

    sequence s_event_fall_match;
        event_on && !low_speed_mode && ev_fall && st_reg.cnt == st_reg.cmp;
    endsequence

    chk_timer_count_up: assert property (
        timer_on && int_tick && st_reg.cnt != st_reg.cmp
        |=> st_reg.cnt == $past(st_reg.cnt) + 8'h01 && !match_irq)
        else $error("timer did not count up on tick");

    chk_timer_match_clear: assert property (
        timer_on && int_tick && st_reg.cnt == st_reg.cmp
        |=> st_reg.cnt == 8'h00 && match_irq)
        else $error("timer match did not clear and request");

    chk_event_rise_count: assert property (
        s_event_rise_seen |=> st_reg.cnt == $past(st_reg.cnt) + 8'h01)
        else $error("event rise did not count");

    chk_event_fall_irq: assert property (
        s_event_fall_match |=> match_irq && st_reg.cnt == 8'h00
        ##1 !match_irq)
        else $error("event match not taken at falling edge");

    chk_event_lowspeed_hold: assert property (
        event_on && low_speed_mode |=> $stable(st_reg.cnt) && !match_irq)
        else $error("event counted in low-speed mode");

    chk_pdo_toggle_out: assert property (
        pdo_on && int_tick && st_reg.cnt == st_reg.cmp
        |=> divider_out != $past(divider_out) && match_irq
        && st_reg.cnt == 8'h00)
        else $error("divider match did not toggle");

    chk_stop_outputs_high: assert property (
        !st_reg.run ##1 !st_reg.run |-> divider_out && pwm_out_n
        && st_reg.cnt == 8'h00)
        else $error("outputs not high while stopped");

    chk_pwm_match_low: assert property (
        pwm_on && int_tick && st_reg.cnt != tepc_pkg::COUNT_TOP
        && st_reg.cnt + 8'h01 == st_reg.act
        |=> !pwm_out_n && !match_irq)
        else $error("PWM match did not drive low");

    chk_pwm_overflow_high: assert property (
        pwm_on && int_tick && st_reg.cnt == tepc_pkg::COUNT_TOP
        |=> pwm_out_n && match_irq && st_reg.cnt == 8'h00
        && st_reg.act == $past(st_reg.cmp))
        else $error("PWM overflow not handled");

    chk_pwm_start_load: assert property (
        wr_ctrl && pwdata[tepc_pkg::RUN_BIT_POS] && !st_reg.run
        && !stop_mode_entry
        |=> st_reg.act == $past(st_reg.cmp) && st_reg.run)
        else $error("start did not load active compare");

    chk_stop_clears_run: assert property (
        stop_mode_entry |=> !st_reg.run ##1 st_reg.cnt == 8'h00)
        else $error("stop entry left the timer running");

    chk_irq_single_pulse: assert property (
        match_irq && st_reg.cmp != 8'h00
        |=> !match_irq)
        else $error("request held longer than one cycle");

endmodule : tepc_timer
`default_nettype wire

// >>> tb/tepc_event_src.sv
`timescale 1ns/1ps
`default_nettype none
// Pulses on the event pin; the pin rests low between bursts
module tepc_event_src #(
    parameter int HALF = 10
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic go,
    input wire logic [7:0] n_pulses,
    output logic event_in,
    output logic busy
);
    int left;
    int ph;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            event_in <= 1'b0;
            busy <= 1'b0;
            left <= 0;
            ph <= 0;
        end else if (go && !busy) begin
            busy <= 1'b1;
            left <= 2 * int'(n_pulses);
            ph <= 0;
        end else if (busy) begin
            // Each level is held HALF cycles, above the eight-period floor
            if (ph == HALF - 1) begin
                ph <= 0;
                event_in <= ~event_in;
                left <= left - 1;
                busy <= (left > 1);
            end else begin
                ph <= ph + 1;
            end
        end
    end
endmodule : tepc_event_src
`default_nettype wire

// >>> tb/timer_event_pdo_pwm_counter8_test.sv
`timescale 1ns/1ps
`default_nettype none
module timer_event_pdo_pwm_counter8_test;
    logic clk_sys, arst_n, psel, penable, pwrite, pready, pslverr, se;
    logic [tepc_pkg::ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic event_in, low_speed_mode, stop_mode_entry, match_irq;
    logic divider_out, pwm_out_n, ev_go, ev_busy, tick_phase, irq_pwm;
    logic [tepc_pkg::N_INT_SRC-1:0] src_tick, tick_mask;
    logic [7:0] ev_count;
    int n_errors, n_tests, n_cyc, n_irq, n_low, t1, t2;

    tepc_timer dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .src_tick(src_tick), .event_in(event_in),
        .low_speed_mode(low_speed_mode), .stop_mode_entry(stop_mode_entry),
        .match_irq(match_irq), .divider_out(divider_out),
        .pwm_out_n(pwm_out_n));
    tepc_event_src ev_u (.clk_sys(clk_sys), .arst_n(arst_n), .go(ev_go),
        .n_pulses(ev_count), .event_in(event_in), .busy(ev_busy));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // Ticks every other cycle so a stuck select shows up as wrong spacing
    always @(posedge clk_sys) begin
        tick_phase <= ~tick_phase;
        src_tick <= tick_phase ? tick_mask : '0;
        n_cyc <= n_cyc + 1;
        if (match_irq === 1'b1) n_irq <= n_irq + 1;
        if (pwm_out_n === 1'b0) n_low <= n_low + 1;
        if (n_cyc == 30000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Setup, then access held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [9:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // No wait-state count assumed; the cycle ceiling ends a hang
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_irq(output int at);
        do begin
            @(posedge clk_sys);
        end while (match_irq !== 1'b1);
        at = n_cyc;
        irq_pwm = pwm_out_n;
        @(posedge clk_sys);
        check(match_irq, 1'b0);
    endtask : wait_irq

    initial begin
        {psel, penable, pwrite, ev_go, stop_mode_entry} = '0;
        {low_speed_mode, tick_phase, src_tick, tick_mask} = '0;
        paddr = '0;
        pwdata = '0;
        ev_count = '0;
        {n_errors, n_tests, n_cyc, n_irq, n_low} = '0;
        arst_n = 1'b0;
        repeat (8) @(posedge clk_sys);
        arst_n <= 1'b1;
        apb(1'b0, tepc_pkg::ADDR_CONTROL, 0); check(rd, 32'h00);
        apb(1'b0, tepc_pkg::ADDR_COMPARE, 0); check(rd, 32'hFF);
        apb(1'b0, tepc_pkg::ADDR_STATUS, 0); check(rd, 32'h00FF0300);
        apb(1'b0, 10'h3FC, 0); check({se, rd[30:0]}, 32'h80000000);
        // Timer, select 3: match every compare+1 ticks
        tick_mask <= 7'h08;
        apb(1'b1, tepc_pkg::ADDR_COMPARE, 32'h03);
        apb(1'b1, tepc_pkg::ADDR_CONTROL, 32'h2C);
        wait_irq(t1);
        wait_irq(t2); check(t2 - t1, 8);
        apb(1'b1, tepc_pkg::ADDR_CONTROL, 32'h0C);
        apb(1'b0, tepc_pkg::ADDR_STATUS, 0); check(rd[7:0], 8'h00);
        // Reserved mode must hold the counter and never request
        t1 = n_irq;
        apb(1'b1, tepc_pkg::ADDR_CONTROL, 32'h2D);
        repeat (12) @(posedge clk_sys);
        apb(1'b0, tepc_pkg::ADDR_STATUS, 0); check(rd[7:0], 8'h00);
        check(n_irq - t1, 0);
        apb(1'b1, tepc_pkg::ADDR_CONTROL, 32'h0C);
        // Divider: toggles on each match
        apb(1'b1, tepc_pkg::ADDR_COMPARE, 32'h02);
        apb(1'b1, tepc_pkg::ADDR_CONTROL, 32'h2E);
        wait_irq(t1); check(divider_out, 1'b0);
        wait_irq(t2); check(divider_out, 1'b1);
        check(t2 - t1, 6);
        wait_irq(t1);
        apb(1'b1, tepc_pkg::ADDR_CONTROL, 32'h0E);
        apb(1'b0, tepc_pkg::ADDR_STATUS, 0); check(rd[8], 1'b1);
        check(divider_out, 1'b1);
        // Event counting from the pin: 4 pulses, then 3 in low-speed mode; compare 2
        apb(1'b1, tepc_pkg::ADDR_CONTROL, 32'h3C);
        for (int b = 0; b < 2; b++) begin
            t1 = n_irq;
            low_speed_mode <= (b == 1);
            // Three pulses would reach the compare if low speed were ignored
            ev_count <= (b == 0) ? 8'd4 : 8'd3;
            ev_go <= 1'b1;
            @(posedge clk_sys);
            ev_go <= 1'b0;
            do begin
                @(posedge clk_sys);
            end while (ev_busy);
            repeat (8) @(posedge clk_sys);
            check(n_irq - t1, (b == 0) ? 2 : 0);
            apb(1'b0, tepc_pkg::ADDR_STATUS, 0); check(rd[7:0], 8'h00);
        end
        low_speed_mode <= 1'b0;
        apb(1'b1, tepc_pkg::ADDR_CONTROL, 32'h1C);
        // PWM with shadowed compare
        apb(1'b1, tepc_pkg::ADDR_COMPARE, 32'h80);
        apb(1'b1, tepc_pkg::ADDR_CONTROL, 32'h2F);
        apb(1'b0, tepc_pkg::ADDR_STATUS, 0); check(rd[23:16], 8'h80);
        wait_irq(t1); check(irq_pwm, 1'b1);
        apb(1'b1, tepc_pkg::ADDR_COMPARE, 32'hC0);
        t1 = n_low;
        wait_irq(t2); check(n_low - t1, 256);
        t1 = n_low;
        wait_irq(t2); check(n_low - t1, 128);
        low_speed_mode <= 1'b1;
        apb(1'b0, tepc_pkg::ADDR_STATUS, 0);
        t1 = int'(rd[7:0]);
        apb(1'b0, tepc_pkg::ADDR_STATUS, 0); check(rd[7:0], t1);
        low_speed_mode <= 1'b0;
        // Stop inside a low phase so the forced-high output is visible
        do begin
            @(posedge clk_sys);
        end while (pwm_out_n !== 1'b0);
        stop_mode_entry <= 1'b1;
        @(posedge clk_sys);
        stop_mode_entry <= 1'b0;
        apb(1'b0, tepc_pkg::ADDR_CONTROL, 0); check(rd, 32'h0F);
        check(pwm_out_n, 1'b1);
        apb(1'b0, tepc_pkg::ADDR_STATUS, 0); check(rd[9:0], 10'h300);
        tally_and_finish();
    end
endmodule : timer_event_pdo_pwm_counter8_test
`default_nettype wire
